// file: hdl/asc_pkg.sv
// package: constants and types shared by the serial control ends
package asc_pkg;
  localparam int          ACC_BITS       = 16;
  localparam int          BYTE_BITS      = 8;
  localparam logic [4:0]  CNT_FULL       = 5'h10;
  localparam logic [4:0]  CNT_BYTE       = 5'h08;
  localparam logic [1:0]  ADDR_CONTROL   = 2'h0;
  localparam logic [1:0]  ADDR_PAT_HIGH  = 2'h1;
  localparam logic [1:0]  ADDR_PAT_LOW   = 2'h2;
  localparam logic [7:0]  CONTROL_RESET  = 8'h08;
  localparam logic [7:0]  PAT_HIGH_RESET = 8'h00;
  localparam logic [7:0]  PAT_LOW_RESET  = 8'h00;
  localparam logic [1:0]  ADDR_RESET     = 2'h0;
  localparam logic [7:0]  PAT_HIGH_MASK  = 8'h3F;
  localparam int          MODE_HI        = 7;
  localparam int          MODE_LO        = 6;
  localparam int          LANE_BIT       = 5;
  localparam int          STAB_BIT       = 4;
  localparam int          CODING_BIT     = 3;
  localparam int          ALIGN_BIT      = 2;
  localparam int          SLEEP_A_BIT    = 1;
  localparam int          SLEEP_B_BIT    = 0;
  localparam int          RW_BIT         = 7;
  localparam logic [1:0]  MODE_NORMAL    = 2'h0;
  localparam logic [1:0]  MODE_FIXED     = 2'h1;
  localparam logic [1:0]  MODE_USER      = 2'h2;
  localparam logic [13:0] FIXED_WORD     = 14'h298E;
  // host clock divider: half period of serial clock is HALF_DIV + 1 clk_i cycles
  localparam logic [3:0]  HALF_DIV       = 4'h4;
  // wishbone register offsets of the host controller
  localparam logic [3:0]  WB_CMD         = 4'h0;
  localparam logic [3:0]  WB_STATUS      = 4'h4;
  localparam logic [3:0]  WB_RDATA       = 4'h8;
  localparam int          CMD_GO_BIT     = 16;
  typedef enum logic [1:0] {ASC_IDLE, ASC_LOW, ASC_HIGH, ASC_END} asc_hstate_t;
endpackage : asc_pkg

// file: hdl/asc_if.sv
// interface: serial control link between host and converter control
`timescale 1ns/10ps
`default_nettype none
interface asc_if;
  logic sclk;
  logic serial_select_n;
  logic sdi;
  logic sdo;
  logic sdo_oe;
  modport dev  (input sclk, serial_select_n, sdi, output sdo, sdo_oe);
  modport host (output sclk, serial_select_n, sdi, input sdo, sdo_oe);
endinterface : asc_if
`default_nettype wire

// file: hdl/asc_sync.sv
// two flip-flop synchroniser for an input from outside the clock domain
`timescale 1ns/10ps
`default_nettype none
module asc_sync (
  input  wire logic clk_i, // clock
  input  wire logic rst_i, // sync reset
  input  wire logic d_i,   // async input
  output logic      q_o    // synchronised level
);
  logic meta;
  logic q;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta <= 1'b0;
      q    <= 1'b0;
    end
    else
    begin
      meta <= d_i;
      q    <= meta;
    end
  end
  assign q_o = q;
endmodule : asc_sync
`default_nettype wire

// file: hdl/asc_dev.sv
// converter control end: serial slave, control registers and strap select
`timescale 1ns/10ps
`default_nettype none
module asc_dev
  import asc_pkg::*;
(
  input  wire logic   clk_i,              // sample clock domain
  input  wire logic   rst_i,              // sync reset, high
  asc_if.dev          link,               // serial control link
  input  wire logic   serial_enable_i,    // register control enable
  input  wire logic   chan_a_sleep_pin_i, // channel a sleep strap
  input  wire logic   chan_b_sleep_pin_i, // channel b sleep strap
  input  wire logic   lane_config_select_i, // lane strap
  input  wire logic   word_align_select_i,  // alignment strap
  input  wire logic   test_pin_i,         // fixed pattern strap
  input  wire logic   coding_strap_i,     // coding strap
  input  wire logic   stabilizer_strap_i, // stabilizer strap
  input  wire logic   dll_locked_i,       // dll lock from core
  input  wire logic   frame_i,            // one pulse per output frame
  input  wire logic   chan_a_oor_i,       // channel a out of range
  input  wire logic   chan_b_oor_i,       // channel b out of range
  output logic [1:0]  operating_mode_field_o, // effective mode
  output logic [13:0] test_word_o,        // word shown in test mode
  output logic        lane_config_o,      // 1 single lane
  output logic        lane_zero_park_o,   // lane zero high impedance
  output logic        duty_stabilizer_on_o, // stabilizer enable
  output logic        output_coding_select_o, // 1 twos complement
  output logic        word_align_o,       // effective alignment
  output logic        chan_a_sleep_o,     // channel a power-down
  output logic        chan_b_sleep_o,     // channel b power-down
  output logic        dll_lock_o,         // lock status
  output logic        chan_a_overrange_o, // channel a overrange
  output logic        chan_b_overrange_o  // channel b overrange
);
  import asc_pkg::*;

  typedef struct packed {
    logic        sclk_d;
    logic        sel_d;
    logic [4:0]  cnt;
    logic [15:0] shift;
    logic [1:0]  rd_addr;
    logic [7:0]  out_byte;
    logic        sdo;
    logic [7:0]  control;
    logic [7:0]  pat_high;
    logic [7:0]  pat_low;
    logic [1:0]  mode;
    logic [13:0] word;
    logic        lane;
    logic        stab;
    logic        coding;
    logic        align;
    logic        sleep_a;
    logic        sleep_b;
    logic        lock;
    logic        chan_a_overrange;
    logic        chan_b_overrange;
  } asc_dev_t;

  asc_dev_t r;
  asc_dev_t next_r;
  logic     sclk_s;
  logic     sel_n_s;
  logic     sdi_s;
  logic     en_s;
  logic     lock_s;
  logic     rise;
  logic     fall;
  logic     sel_rise;
  logic     sel_fall;
  logic [7:0] sel_reg;
  logic [1:0] strap_mode;
  logic       pin_a_s;
  logic       pin_b_s;
  logic       lane_pin_s;
  logic       align_pin_s;
  logic       test_pin_s;
  logic       code_pin_s;
  logic       stab_pin_s;

  asc_sync u_sync_sclk (.clk_i(clk_i), .rst_i(rst_i),
                        .d_i(link.sclk), .q_o(sclk_s));
  asc_sync u_sync_sel (.clk_i(clk_i), .rst_i(rst_i),
                       .d_i(~link.serial_select_n), .q_o(sel_n_s));
  asc_sync u_sync_sdi (.clk_i(clk_i), .rst_i(rst_i),
                       .d_i(link.sdi), .q_o(sdi_s));
  asc_sync u_sync_en (.clk_i(clk_i), .rst_i(rst_i),
                      .d_i(serial_enable_i), .q_o(en_s));
  asc_sync u_sync_lock (.clk_i(clk_i), .rst_i(rst_i),
                        .d_i(dll_locked_i), .q_o(lock_s));
  // straps are board pins, so they cross like any other pin
  asc_sync u_sync_pin_a (.clk_i(clk_i), .rst_i(rst_i),
                         .d_i(chan_a_sleep_pin_i), .q_o(pin_a_s));
  asc_sync u_sync_pin_b (.clk_i(clk_i), .rst_i(rst_i),
                         .d_i(chan_b_sleep_pin_i), .q_o(pin_b_s));
  asc_sync u_sync_lane (.clk_i(clk_i), .rst_i(rst_i),
                        .d_i(lane_config_select_i), .q_o(lane_pin_s));
  asc_sync u_sync_align (.clk_i(clk_i), .rst_i(rst_i),
                         .d_i(word_align_select_i), .q_o(align_pin_s));
  asc_sync u_sync_test (.clk_i(clk_i), .rst_i(rst_i),
                        .d_i(test_pin_i), .q_o(test_pin_s));
  asc_sync u_sync_code (.clk_i(clk_i), .rst_i(rst_i),
                        .d_i(coding_strap_i), .q_o(code_pin_s));
  asc_sync u_sync_stab (.clk_i(clk_i), .rst_i(rst_i),
                        .d_i(stabilizer_strap_i), .q_o(stab_pin_s));

  // sel_n_s is the select active-high after synchronising
  assign rise     = sclk_s & ~r.sclk_d;
  assign fall     = ~sclk_s & r.sclk_d;
  assign sel_rise = sel_n_s & ~r.sel_d;
  assign sel_fall = ~sel_n_s & r.sel_d;

  always_comb
  begin
    next_r        = r;
    next_r.sclk_d = sclk_s;
    next_r.sel_d  = sel_n_s;
    sel_reg       = 8'h00;
    strap_mode    = test_pin_s ? MODE_FIXED : MODE_NORMAL;
    if (sel_rise)
    begin
      next_r.cnt   = 5'h00;
      next_r.shift = 16'h0000;
    end
    else if (sel_n_s && en_s && rise && r.cnt != CNT_FULL)
    begin
      next_r.shift = {r.shift[14:0], sdi_s};
      next_r.cnt   = r.cnt + 5'h01;
    end
    case (r.shift[1:0])
      ADDR_CONTROL:  sel_reg = r.control;
      ADDR_PAT_HIGH: sel_reg = r.pat_high;
      ADDR_PAT_LOW:  sel_reg = r.pat_low;
      default:       sel_reg = 8'h00;
    endcase
    // readback of the register named in the current first byte; its
    // msb leaves on the eighth fall so the host has it by the ninth
    if (sel_n_s && fall && r.cnt == CNT_BYTE)
    begin
      next_r.out_byte = {sel_reg[6:0], 1'b0};
      next_r.sdo      = sel_reg[7];
    end
    else if (sel_n_s && fall && r.cnt > CNT_BYTE)
    begin
      next_r.out_byte = {r.out_byte[6:0], 1'b0};
      next_r.sdo      = r.out_byte[7];
    end
    else if (sel_n_s && fall)
      next_r.sdo = 1'b0;
    // an early deselect leaves count short, so nothing is latched
    if (sel_fall && en_s && r.cnt == CNT_FULL)
    begin
      next_r.rd_addr = r.shift[9:8];
      if (!r.shift[RW_BIT + 8])
      begin
        case (r.shift[9:8])
          ADDR_CONTROL:  next_r.control  = r.shift[7:0];
          // reserved top bits of pattern high stay zero
          ADDR_PAT_HIGH: next_r.pat_high = r.shift[7:0] & PAT_HIGH_MASK;
          ADDR_PAT_LOW:  next_r.pat_low  = r.shift[7:0];
          default:       ;
        endcase
      end
    end
    if (en_s)
    begin
      next_r.mode    = r.control[MODE_HI:MODE_LO];
      next_r.lane    = r.control[LANE_BIT];
      next_r.stab    = r.control[STAB_BIT];
      next_r.coding  = r.control[CODING_BIT];
      next_r.align   = r.control[ALIGN_BIT];
      // sleep pins are ignored while the registers govern
      next_r.sleep_a = r.control[SLEEP_A_BIT];
      next_r.sleep_b = r.control[SLEEP_B_BIT];
    end
    else
    begin
      next_r.mode    = strap_mode;
      next_r.lane    = lane_pin_s;
      next_r.stab    = stab_pin_s;
      next_r.coding  = code_pin_s;
      next_r.align   = align_pin_s;
      next_r.sleep_a = pin_a_s;
      next_r.sleep_b = pin_b_s;
    end
    if (next_r.lane)
      next_r.align = 1'b0;
    case (next_r.mode)
      MODE_FIXED: next_r.word = FIXED_WORD;
      MODE_USER:  next_r.word = {r.pat_high[5:0], r.pat_low};
      default:    next_r.word = 14'h0000;
    endcase
    next_r.lock = lock_s;
    if (frame_i)
    begin
      next_r.chan_a_overrange = chan_a_oor_i;
      next_r.chan_b_overrange = chan_b_oor_i;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      r          <= '0;
      r.rd_addr  <= ADDR_RESET;
      r.control  <= CONTROL_RESET;
      r.pat_high <= PAT_HIGH_RESET;
      r.pat_low  <= PAT_LOW_RESET;
    end
    else
      r <= next_r;
  end

  assign link.sdo               = r.sdo;
  assign link.sdo_oe            = sel_n_s & en_s;
  assign operating_mode_field_o = r.mode;
  assign test_word_o            = r.word;
  assign lane_config_o          = r.lane;
  assign lane_zero_park_o       = r.lane;
  assign duty_stabilizer_on_o   = r.stab;
  assign output_coding_select_o = r.coding;
  assign word_align_o           = r.align;
  assign chan_a_sleep_o         = r.sleep_a;
  assign chan_b_sleep_o         = r.sleep_b;
  assign dll_lock_o             = r.lock;
  assign chan_a_overrange_o     = r.chan_a_overrange;
  assign chan_b_overrange_o     = r.chan_b_overrange;
endmodule : asc_dev
`default_nettype wire

// file: hdl/asc_host.sv
// host end: wishbone-controlled serial master for the control link
`timescale 1ns/10ps
`default_nettype none
module asc_host
  import asc_pkg::*;
(
  input  wire logic        clk_i, // clock
  input  wire logic        rst_i, // sync reset, high
  asc_if.host              link,  // serial control link
  input  wire logic        cyc_i, // wishbone cycle
  input  wire logic        stb_i, // wishbone strobe
  input  wire logic        we_i,  // wishbone write
  input  wire logic [3:0]  adr_i, // wishbone byte address
  input  wire logic [3:0]  sel_i, // wishbone byte selects
  input  wire logic [31:0] dat_i, // wishbone write data
  output logic [31:0]      dat_o, // wishbone read data
  output logic             ack_o  // wishbone acknowledge
);
  import asc_pkg::*;

  typedef struct packed {
    asc_hstate_t st;
    logic [3:0]  div;
    logic [4:0]  cnt;
    logic [15:0] tx;
    logic [7:0]  rx;
    logic        sclk;
    logic        sel_n;
    logic [31:0] dat;
    logic        ack;
  } asc_host_r_t;

  asc_host_r_t r;
  asc_host_r_t next_r;
  logic        sdo_s;

  asc_sync u_sync_sdo (.clk_i(clk_i), .rst_i(rst_i),
                       .d_i(link.sdo & link.sdo_oe), .q_o(sdo_s));

  always_comb
  begin
    next_r     = r;
    next_r.ack = 1'b0;
    if (cyc_i && stb_i && !r.ack)
    begin
      next_r.ack = 1'b1;
      next_r.dat = 32'h0000_0000;
      case (adr_i)
        WB_CMD:
          if (we_i && sel_i[2] && r.st == ASC_IDLE && dat_i[CMD_GO_BIT])
          begin
            // reserved command bits are sent as zero
            next_r.tx    = {dat_i[15], 5'h00, dat_i[9:8], dat_i[7:0]};
            next_r.st    = ASC_LOW;
            next_r.sel_n = 1'b0;
            next_r.cnt   = 5'h00;
            next_r.div   = 4'h0;
          end
        WB_STATUS: next_r.dat = {31'h0, r.st != ASC_IDLE};
        WB_RDATA:  next_r.dat = {24'h0, r.rx};
        default:   next_r.dat = 32'h0000_0000;
      endcase
    end
    case (r.st)
      ASC_IDLE: ;
      ASC_LOW:
      begin
        next_r.div = r.div + 4'h1;
        if (r.div == HALF_DIV)
        begin
          next_r.div  = 4'h0;
          next_r.sclk = 1'b1;
          next_r.st   = ASC_HIGH;
        end
      end
      ASC_HIGH:
      begin
        next_r.div = r.div + 4'h1;
        if (r.div == HALF_DIV)
        begin
          next_r.div  = 4'h0;
          next_r.sclk = 1'b0;
          next_r.tx   = {r.tx[14:0], 1'b0};
          next_r.cnt  = r.cnt + 5'h01;
          if (r.cnt >= CNT_BYTE)
            next_r.rx = {r.rx[6:0], sdo_s};
          next_r.st = (r.cnt == CNT_FULL - 5'h01) ? ASC_END : ASC_LOW;
        end
      end
      ASC_END:
      begin
        next_r.div = r.div + 4'h1;
        if (r.div == HALF_DIV)
        begin
          next_r.sel_n = 1'b1;
          next_r.st    = ASC_IDLE;
        end
      end
      default: next_r.st = ASC_IDLE;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      r       <= '0;
      r.st    <= ASC_IDLE;
      r.sel_n <= 1'b1;
    end
    else
      r <= next_r;
  end

  assign link.sclk            = r.sclk;
  assign link.serial_select_n = r.sel_n;
  assign link.sdi             = r.tx[15];
  assign dat_o                = r.dat;
  assign ack_o                = r.ack;
endmodule : asc_host
`default_nettype wire

// file: dv/asc_chk.sv
// checker: timing relations on the serial control link
`timescale 1ns/10ps
`default_nettype none
module asc_chk (
  input  wire logic clk_i,           // clock
  input  wire logic rst_i,           // sync reset, high
  input  wire logic sclk,            // serial clock
  input  wire logic serial_select_n, // select, active low
  input  wire logic sdi,             // host data
  input  wire logic sdo,             // device data
  input  wire logic sdo_oe           // device drive enable
);
  logic       sclk_q;
  logic [4:0] n_rise;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // ==========================================================
  // helper: serial clock rises inside one select window
  always_ff @(posedge clk_i)
  begin
    sclk_q <= sclk;
    if (rst_i || serial_select_n)
      n_rise <= 5'h00;
    else if (sclk && !sclk_q)
      n_rise <= n_rise + 5'h01;
  end
  // ==========================================================
  // properties
  sequence s_open;
    $fell(serial_select_n);
  endsequence
  sequence s_close;
    ##[150:180] $rose(serial_select_n);
  endsequence
  property p_frame_len;
    s_open |-> s_close;
  endproperty
  property p_bit_count;
    $rose(serial_select_n) |-> n_rise == 5'h10;
  endproperty
  property p_oe_off;
    serial_select_n [*4] |-> !sdo_oe;
  endproperty
  property p_sclk_idle;
    serial_select_n |-> !sclk;
  endproperty
  property p_sclk_high;
    $rose(sclk) |-> sclk [*5] ##1 !sclk;
  endproperty
  property p_sclk_low;
    $fell(sclk) |-> !sclk [*5];
  endproperty
  property p_sdi_hold;
    sclk && $past(sclk) |-> $stable(sdi);
  endproperty
  // device only shifts on falling edges, so sdo is quiet while high
  property p_sdo_hold;
    sclk && $past(sclk) && sdo_oe && $past(sdo_oe) |-> $stable(sdo);
  endproperty
  a_frame_len: assert property (p_frame_len)
    else $error("select window length wrong");
  a_bit_count: assert property (p_bit_count)
    else $error("access not sixteen clocks");
  a_oe_off: assert property (p_oe_off)
    else $error("sdo driven while deselected");
  a_sclk_idle: assert property (p_sclk_idle)
    else $error("serial clock high outside access");
  a_sclk_high: assert property (p_sclk_high)
    else $error("serial clock high phase wrong");
  a_sclk_low: assert property (p_sclk_low)
    else $error("serial clock low phase short");
  a_sdi_hold: assert property (p_sdi_hold)
    else $error("sdi moved while clock high");
  a_sdo_hold: assert property (p_sdo_hold)
    else $error("sdo moved while clock high");
endmodule : asc_chk
`default_nettype wire

// file: dv/asc_test.sv
// testbench: host and converter control joined over the serial link
`timescale 1ns/10ps
`default_nettype none
module asc_test
  import asc_pkg::*;
;
  localparam logic [7:0] TV [6] = '{8'h00, 8'h44, 8'h80, 8'h2C, 8'h17, 8'h9B};
  logic        clk_i, rst_i, cyc, stb, we, ack, en, pin_a, pin_b, lane_s;
  logic        align_s, test_s, code_s, stab_s, lock, frame, oor_a, oor_b;
  logic        lane, park, stab, code, align, slp_a, slp_b, lock_o, ov_a, ov_b;
  logic [1:0]  mode;
  logic [13:0] word, word2;
  logic [3:0]  adr;
  logic [31:0] dat, dat_o;
  logic [22:0] outs;
  int          n_fail, num_checks;
  asc_if u_asc_if ();
  asc_if u_asc_if2 ();
  assign outs = {mode, word, lane, park, stab, code, align, slp_a, slp_b};
  always #50 clk_i = ~clk_i;
  asc_host u_asc_host (.clk_i, .rst_i, .link(u_asc_if), .cyc_i(cyc),
    .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'hF), .dat_i(dat),
    .dat_o(dat_o), .ack_o(ack));
  asc_dev u_asc_dev (.clk_i, .rst_i, .link(u_asc_if), .serial_enable_i(en),
    .chan_a_sleep_pin_i(pin_a), .chan_b_sleep_pin_i(pin_b),
    .lane_config_select_i(lane_s), .word_align_select_i(align_s),
    .test_pin_i(test_s), .coding_strap_i(code_s), .stabilizer_strap_i(stab_s),
    .dll_locked_i(lock), .frame_i(frame), .chan_a_oor_i(oor_a),
    .chan_b_oor_i(oor_b), .operating_mode_field_o(mode), .test_word_o(word),
    .lane_config_o(lane), .lane_zero_park_o(park),
    .duty_stabilizer_on_o(stab), .output_coding_select_o(code),
    .word_align_o(align), .chan_a_sleep_o(slp_a), .chan_b_sleep_o(slp_b),
    .dll_lock_o(lock_o), .chan_a_overrange_o(ov_a), .chan_b_overrange_o(ov_b));
  // second device end, driven by hand to break the framing on purpose
  asc_dev u_asc_dev2 (.clk_i, .rst_i, .link(u_asc_if2), .serial_enable_i(en),
    .chan_a_sleep_pin_i(pin_a), .chan_b_sleep_pin_i(pin_b),
    .lane_config_select_i(lane_s), .word_align_select_i(align_s),
    .test_pin_i(test_s), .coding_strap_i(code_s), .stabilizer_strap_i(stab_s),
    .dll_locked_i(lock), .frame_i(frame), .chan_a_oor_i(oor_a),
    .chan_b_oor_i(oor_b), .operating_mode_field_o(), .test_word_o(word2),
    .lane_config_o(), .lane_zero_park_o(), .duty_stabilizer_on_o(),
    .output_coding_select_o(), .word_align_o(), .chan_a_sleep_o(),
    .chan_b_sleep_o(), .dll_lock_o(), .chan_a_overrange_o(),
    .chan_b_overrange_o());
  asc_chk u_asc_chk (.clk_i, .rst_i, .sclk(u_asc_if.sclk),
    .serial_select_n(u_asc_if.serial_select_n), .sdi(u_asc_if.sdi),
    .sdo(u_asc_if.sdo), .sdo_oe(u_asc_if.sdo_oe));
  // ==========================================================
  // helpers
  task summarize();
    if (n_fail == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : summarize
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e)
    begin
      n_fail++;
      $display("mismatch %s exp %h seen %h", nm, e, s);
    end
  endtask : chk
  function automatic logic [22:0] expo(input logic [7:0] v,
                                       input logic [13:0] pw);
    logic [13:0] w;
    w = (v[7:6] == MODE_FIXED) ? FIXED_WORD :
        (v[7:6] == MODE_USER) ? pw : 14'h0000;
    return {v[7:6], w, v[5], v[5], v[4], v[3], v[2] & ~v[5], v[1], v[0]};
  endfunction : expo
  task wb(input logic w, input logic [3:0] a, input logic [31:0] d,
          output logic [31:0] q);
    int i;
    i = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    do
    begin
      @(posedge clk_i);
      i++;
    end
    while (ack !== 1'b1 && i < 50);
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (i >= 50)
    begin
      n_fail++;
      summarize();
    end
  endtask : wb
  task idle();
    logic [31:0] r;
    int          i;
    i = 0;
    r = 32'h1;
    while (r[0] !== 1'b0)
    begin
      wb(1'b0, WB_STATUS, 32'h0, r);
      i++;
      if (i > 500)
      begin
        n_fail++;
        summarize();
      end
    end
  endtask : idle
  task acc(input logic rd, input logic [1:0] a, input logic [7:0] d,
           output logic [7:0] q);
    logic [31:0] r;
    idle();
    wb(1'b1, WB_CMD, {15'h0000, 1'b1, rd, 5'h00, a, d}, r);
    idle();
    // register write lands a few cycles after select rises
    repeat (5) @(posedge clk_i);
    wb(1'b0, WB_RDATA, 32'h0, r);
    q = r[7:0];
  endtask : acc
  task bang(input logic [15:0] w, input int n);
    int i;
    @(posedge clk_i);
    u_asc_if2.serial_select_n <= 1'b0;
    for (i = 0; i < n; i++)
    begin
      // 800 ns link clock: four cycles low, four high
      u_asc_if2.sdi <= w[15-i];
      repeat (4) @(posedge clk_i);
      u_asc_if2.sclk <= 1'b1;
      repeat (4) @(posedge clk_i);
      u_asc_if2.sclk <= 1'b0;
    end
    repeat (5) @(posedge clk_i);
    u_asc_if2.serial_select_n <= 1'b1;
    u_asc_if2.sdi <= ~u_asc_if2.sdi;
    repeat (10) @(posedge clk_i);
  endtask : bang
  // ==========================================================
  // scenarios
  task t_regs();
    logic [7:0]  q;
    logic [31:0] r;
    acc(1'b1, ADDR_CONTROL, 8'h00, q);
    chk("ctl_reset", q, CONTROL_RESET);
    chk("out_reset", outs, expo(CONTROL_RESET, 14'h0000));
    acc(1'b1, ADDR_PAT_LOW, 8'h00, q);
    chk("low_reset", q, PAT_LOW_RESET);
    acc(1'b0, ADDR_PAT_LOW, 8'hA5, q);
    acc(1'b0, ADDR_PAT_HIGH, 8'hFF, q);
    acc(1'b1, ADDR_PAT_HIGH, 8'h00, q);
    chk("pat_high", q, 8'h3F);
    acc(1'b1, 2'h3, 8'h00, q);
    chk("addr3", q, 8'h00);
    wb(1'b0, 4'hC, 32'h0, r);
    // sleep pins high must not reach the outputs under register control
    {pin_a, pin_b} <= 2'b11;
    foreach (TV[k])
    begin
      acc(1'b0, ADDR_CONTROL, TV[k], q);
      chk("fields", outs, expo(TV[k], 14'h3FA5));
    end
    {pin_a, pin_b} <= 2'b00;
    acc(1'b1, ADDR_CONTROL, 8'hFF, q);
    acc(1'b1, ADDR_CONTROL, 8'h00, q);
    chk("rd_no_wr", q, 8'h9B);
  endtask : t_regs
  task t_straps();
    logic [7:0] q;
    en <= 1'b0;
    acc(1'b0, ADDR_CONTROL, 8'hFF, q);
    test_s <= 1'b1;
    lane_s <= 1'b1;
    stab_s <= 1'b1;
    align_s <= 1'b1;
    pin_a <= 1'b1;
    repeat (5) @(posedge clk_i);
    chk("straps", outs, expo(8'h76, 14'h3FA5));
    en <= 1'b1;
    pin_a <= 1'b0;
    pin_b <= 1'b1;
    repeat (5) @(posedge clk_i);
    chk("regs_back", outs, expo(8'h9B, 14'h3FA5) | 23'h1);
    pin_b <= 1'b0;
  endtask : t_straps
  task t_status();
    lock <= 1'b0;
    oor_a <= 1'b1;
    repeat (5) @(posedge clk_i);
    chk("lock_lost", lock_o, 1'b0);
    chk("no_frame", {ov_a, ov_b}, 2'b00);
    repeat (10) @(posedge clk_i); // one microsecond relock pulse
    lock <= 1'b1;
    frame <= 1'b1;
    @(posedge clk_i);
    frame <= 1'b0;
    oor_a <= 1'b0;
    oor_b <= 1'b1;
    repeat (5) @(posedge clk_i);
    chk("locked", lock_o, 1'b1);
    chk("frame_oor", {ov_a, ov_b}, 2'b10);
  endtask : t_status
  task t_abort();
    bang(16'h0080, 16);
    bang(16'h02FF, 15);
    chk("abort", word2, 14'h0000);
    bang(16'h023C, 16);
    chk("fresh", word2, 14'h003C);
  endtask : t_abort
  // ==========================================================
  // main sequence
  initial
  begin
    {clk_i, cyc, stb, we, pin_a, pin_b, lane_s, align_s} = 8'h00;
    {test_s, code_s, stab_s, frame, oor_a, oor_b} = 6'h00;
    {u_asc_if2.sclk, u_asc_if2.sdi} = 2'h0;
    u_asc_if2.serial_select_n = 1'b1;
    adr = 4'h0;
    dat = 32'h0;
    en = 1'b1;
    lock = 1'b1;
    rst_i = 1'b1;
    n_fail = 0;
    num_checks = 0;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_straps();
    t_status();
    t_abort();
    summarize();
  end
endmodule : asc_test
`default_nettype wire
